// ===== event_latch.sv
// package of shared status constants and the sticky event latch module
`timescale 1ns/10ps

// ****************************************************************
// shared constants
// ****************************************************************
package status_pkg;
  localparam int BYTE_W = 8;
  // status summary byte bit positions
  localparam int STB_OPER = 7;
  localparam int STB_SERVICE = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_UNUSED3 = 3;
  localparam int STB_ERR = 2;
  localparam int STB_UNUSED1 = 1;
  localparam int STB_READY = 0;
  // standard event flag bit positions
  localparam int ESR_PON = 7;
  localparam int ESR_URQ = 6;
  localparam int ESR_CMD = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_RQC = 1;
  localparam int ESR_OPC = 0;
  // reset values
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] ESE_RESET = 8'h00;
  // service bit can never raise a service request
  localparam logic [7:0] SRE_GATE_MASK = 8'hBF;
  // lower status layers are 16 bits wide with the top bit kept unused
  localparam int LOWER_REG_W = 16;
  localparam int LOWER_UNUSED_BIT = 15;
endpackage

// ****************************************************************
// sticky event latch: set wins over clear
// ****************************************************************
module event_latch #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] set_in,
  input wire logic clear_in,
  output logic [W-1:0] flags_out
);
  typedef struct packed {
    logic [W-1:0] flags;
  } latch_s;

  latch_s q;
  latch_s d;

  // clear first, then new events, so a same-cycle event survives
  always_comb begin
    d = q;
    if (clear_in) begin
      d.flags = '0;
    end
    d.flags = d.flags | set_in;
  end

  // register the state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q.flags <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  assign flags_out = q.flags;
endmodule

// ===== host_model.sv
// remote host model that issues queries and mask writes to the status block
`timescale 1ns/10ps

// ****************************************************************
// host command strobes
// ****************************************************************
module host_model (
  input wire logic clk_in,
  input wire logic reply_valid_in,
  output logic serial_poll_out,
  output logic status_query_out,
  output logic event_query_out,
  output logic clear_status_out,
  output logic sre_write_out,
  output logic ese_write_out,
  output logic [7:0] write_data_out
);
  logic [5:0] strobe_q = 6'h00;
  // one strobe per command kind, poll first
  assign {ese_write_out, sre_write_out, clear_status_out} = strobe_q[5:3];
  assign {event_query_out, status_query_out, serial_poll_out} = strobe_q[2:0];
  initial write_data_out = 8'h00;

  // strobe one cycle, then for a query wait for the answer before anything else
  task automatic send(input int kind, input logic [7:0] data, output bit ok);
    int n;
    ok = 1'b1;
    @(posedge clk_in);
    strobe_q <= 6'h01 << kind;
    write_data_out <= data;
    @(posedge clk_in);
    strobe_q <= 6'h00;
    write_data_out <= ~data; // released data does not keep its value
    if (kind < 3) begin
      // the status is learnt by asking, never from the request line
      for (n = 0; n < 4 && reply_valid_in !== 1'b1; n++) begin
        @(posedge clk_in);
      end
      ok = (reply_valid_in === 1'b1);
    end
  endtask
endmodule

// ===== status_event_reporting.sv
// status summary byte, standard event flags and service request logic
// Function
// [RULE_01] status byte bits: operation 7, service 6, event 5, message 4, error 2, ready 0
// [RULE_02] serial poll returns request flag in bit 6, status query returns summary
// [RULE_03] service enable mask gates status bits onto request; bit 6 never can
// [RULE_04] operation summary bit 7 is never driven active
// [RULE_05] request flag sets with service request, clears on serial poll
// [RULE_06] master summary is read-only, true while an enabled cause exists
// [RULE_07] event summary bit set while any enabled standard event is set
// [RULE_08] message available bit follows unread replies in the output queue
// [RULE_09] error queue bit follows a non-empty command error queue
// [RULE_10] standard event byte: power-on 7 down to operation complete 0
// [RULE_11] standard event enable mask written by program message selects events
// [RULE_12] power-on event set after power cycle until read or cleared
// [RULE_13] user request event set when operator forces local with escape key
// [RULE_14] command error event set when a remote command is rejected
// [RULE_15] execution error event set when a message cannot be carried out
// [RULE_16] device error event set on an internal failure
// [RULE_17] query error event set on protocol violation; host reads replies first
// [RULE_18] request control event is never set
// [RULE_19] operation complete event set when requested functions finished
// [RULE_20] event query returns the flags; they request service only via summary
// [RULE_21] serial port host gets no request signal and must poll the status
// [RULE_22] unused status bits 3 and 1 read zero; ready bit from ready events
// [RULE_23] bit 15 of every 16-bit lower layer register is left unused
`timescale 1ns/10ps

module status_event_reporting (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_poll_in,
  input wire logic status_query_in,
  input wire logic event_query_in,
  input wire logic clear_status_in,
  input wire logic sre_write_in,
  input wire logic ese_write_in,
  input wire logic [7:0] write_data_in,
  input wire logic user_request_in,
  input wire logic command_error_in,
  input wire logic exec_error_in,
  input wire logic device_error_in,
  input wire logic query_error_in,
  input wire logic op_complete_in,
  input wire logic reply_pending_in,
  input wire logic error_queue_in,
  input wire logic ready_event_in,
  output logic [7:0] reply_byte_out,
  output logic reply_valid_out,
  output logic srq_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sre;
    logic [7:0] ese;
    logic mss_prev;
    logic rqs;
    logic [7:0] reply;
    logic reply_valid;
  } state_s;

  state_s q;
  state_s d;
  logic [7:0] esr_flags;
  logic [7:0] esr_set;
  logic esr_clear;
  logic [7:0] stb_base;
  logic mss;

  // ****************************************************************
  // standard event flags
  // ****************************************************************

  // event sources; power-on comes only from the reset value
  always_comb begin
    esr_set = 8'h00;
    esr_set[status_pkg::ESR_URQ] = user_request_in; // [RULE_13]
    esr_set[status_pkg::ESR_CMD] = command_error_in; // [RULE_14]
    esr_set[status_pkg::ESR_EXE] = exec_error_in; // [RULE_15]
    esr_set[status_pkg::ESR_DDE] = device_error_in; // [RULE_16]
    esr_set[status_pkg::ESR_QYE] = query_error_in; // [RULE_17]
    esr_set[status_pkg::ESR_RQC] = 1'b0; // [RULE_18]
    esr_set[status_pkg::ESR_OPC] = op_complete_in; // [RULE_19]
  end

  // reading or clearing empties the flags
  assign esr_clear = event_query_in | clear_status_in; // [RULE_12]

  // sticky flags, power-on set from reset
  event_latch #(
    .W(status_pkg::BYTE_W),
    .RESET_VAL(status_pkg::ESR_RESET) // [RULE_12]
  ) u_esr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(esr_set),
    .clear_in(esr_clear),
    .flags_out(esr_flags) // [RULE_10]
  );

  // ****************************************************************
  // status summary byte
  // ****************************************************************

  // summary bits without the service position
  always_comb begin
    stb_base = 8'h00; // [RULE_01]
    stb_base[status_pkg::STB_OPER] = 1'b0; // [RULE_04]
    stb_base[status_pkg::STB_ESB] = |(esr_flags & q.ese); // [RULE_07]
    stb_base[status_pkg::STB_MAV] = reply_pending_in; // [RULE_08]
    stb_base[status_pkg::STB_UNUSED3] = 1'b0; // [RULE_22]
    stb_base[status_pkg::STB_ERR] = error_queue_in; // [RULE_09]
    stb_base[status_pkg::STB_UNUSED1] = 1'b0; // [RULE_22]
    stb_base[status_pkg::STB_READY] = ready_event_in; // [RULE_22]
  end

  // master summary: any enabled cause, bit 6 excluded
  assign mss = |(stb_base & q.sre & status_pkg::SRE_GATE_MASK); // [RULE_06]

  // ****************************************************************
  // next state
  // ****************************************************************

  // masks, request flag and query replies
  always_comb begin
    d = q;
    d.reply_valid = 1'b0;
    // enable masks written by program message
    if (sre_write_in) begin
      d.sre = write_data_in; // [RULE_03]
    end
    if (ese_write_in) begin
      d.ese = write_data_in; // [RULE_11]
    end
    // request flag: drops with its cause or on poll, new cause wins
    d.mss_prev = mss;
    if (!mss || serial_poll_in) begin
      d.rqs = 1'b0; // [RULE_05]
    end
    if (mss && !q.mss_prev) begin
      d.rqs = 1'b1; // [RULE_05]
    end
    // one reply per request, poll first, then status, then events
    if (serial_poll_in) begin
      d.reply = stb_base;
      d.reply[status_pkg::STB_SERVICE] = q.rqs; // [RULE_02]
      d.reply_valid = 1'b1;
    end else if (status_query_in) begin
      d.reply = stb_base;
      d.reply[status_pkg::STB_SERVICE] = mss; // [RULE_02]
      d.reply_valid = 1'b1;
    end else if (event_query_in) begin
      d.reply = esr_flags; // [RULE_20]
      d.reply_valid = 1'b1;
    end
  end

  // register the state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q.sre <= status_pkg::SRE_RESET;
      q.ese <= status_pkg::ESE_RESET;
      q.mss_prev <= 1'b0;
      q.rqs <= 1'b0;
      q.reply <= 8'h00;
      q.reply_valid <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops; serial port host simply ignores srq
  assign reply_byte_out = q.reply;
  assign reply_valid_out = q.reply_valid;
  assign srq_out = q.rqs; // [RULE_21]

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // no lower layer register exists here, so nothing reaches bit 15
  localparam int UNUSED_TOP = status_pkg::LOWER_UNUSED_BIT; // [RULE_23]

  // helper: reset just released
  logic rst_seen_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  a_pon_after_reset: assert property ( // [RULE_12]
    !rst_seen_q |-> esr_flags[status_pkg::ESR_PON])
    else $error("power-on flag not set after reset");

  a_rqc_never_set: assert property ( // [RULE_18]
    !esr_flags[status_pkg::ESR_RQC])
    else $error("request control flag was set");

  a_oper_bit_low: assert property ( // [RULE_04]
    reply_valid_out && ($past(serial_poll_in) || $past(status_query_in))
      |-> !reply_byte_out[status_pkg::STB_OPER])
    else $error("operation summary bit driven");

  a_unused_bits_zero: assert property ( // [RULE_22]
    reply_valid_out && ($past(serial_poll_in) || $past(status_query_in))
      |-> !reply_byte_out[3] && !reply_byte_out[1])
    else $error("unused status bits not zero");

  a_srq_on_cause: assert property ( // [RULE_05]
    $rose(mss) |=> srq_out)
    else $error("service request not raised on new cause");

  a_poll_clears_rqs: assert property ( // [RULE_05]
    serial_poll_in && !$rose(mss) |=> !srq_out)
    else $error("serial poll did not clear request flag");

  a_no_cause_no_srq: assert property ( // [RULE_06]
    !mss |=> !srq_out)
    else $error("service request without enabled cause");

  a_poll_reply_rqs: assert property ( // [RULE_02]
    serial_poll_in |=> reply_valid_out &&
      reply_byte_out[6] == $past(srq_out))
    else $error("poll reply bit 6 is not request flag");

  a_query_reply_mss: assert property ( // [RULE_02]
    status_query_in && !serial_poll_in |=> reply_valid_out &&
      reply_byte_out[6] == $past(mss) &&
      reply_byte_out[4] == $past(reply_pending_in) &&
      reply_byte_out[2] == $past(error_queue_in))
    else $error("status query reply wrong");

  a_event_read_clears: assert property ( // [RULE_20]
    event_query_in && !serial_poll_in && !status_query_in &&
      esr_set == 8'h00 |=> reply_byte_out == $past(esr_flags) &&
      esr_flags == 8'h00)
    else $error("event query reply or clear wrong");

  a_cmd_error_sticks: assert property ( // [RULE_14]
    command_error_in |=> esr_flags[status_pkg::ESR_CMD])
    else $error("command error event lost");

  a_esb_enabled: assert property ( // [RULE_07]
    (esr_flags & q.ese) != 8'h00 && q.sre[status_pkg::STB_ESB] |-> mss)
    else $error("enabled event did not reach summary");

  // ****************************************************************
  // mask and event flag assertions
  // ****************************************************************

  // a mask write lands whole on the next edge
  a_sre_write_lands: assert property ( // [RULE_03]
    sre_write_in |=> q.sre == $past(write_data_in))
    else $error("service enable mask not written");

  a_ese_write_lands: assert property ( // [RULE_11]
    ese_write_in |=> q.ese == $past(write_data_in))
    else $error("event enable mask not written");

  // each event source latches into its own flag
  a_user_req_sticks: assert property ( // [RULE_13]
    user_request_in |=> esr_flags[status_pkg::ESR_URQ])
    else $error("user request event lost");

  a_exec_err_sticks: assert property ( // [RULE_15]
    exec_error_in |=> esr_flags[status_pkg::ESR_EXE])
    else $error("execution error event lost");

  a_dev_err_sticks: assert property ( // [RULE_16]
    device_error_in |=> esr_flags[status_pkg::ESR_DDE])
    else $error("device error event lost");

  a_query_err_sticks: assert property ( // [RULE_17]
    query_error_in |=> esr_flags[status_pkg::ESR_QYE])
    else $error("query error event lost");

  a_op_done_sticks: assert property ( // [RULE_19]
    op_complete_in |=> esr_flags[status_pkg::ESR_OPC])
    else $error("operation complete event lost");

  // flags only move on an event, a read or a clear
  a_flags_hold: assert property ( // [RULE_10]
    !esr_clear && esr_set == 8'h00 |=> $stable(esr_flags))
    else $error("event flags changed on their own");

  // power-on flag can only come back through reset
  a_pon_stays_low: assert property ( // [RULE_12]
    !esr_flags[status_pkg::ESR_PON] |=> !esr_flags[status_pkg::ESR_PON])
    else $error("power-on flag set without reset");

  // a read or clear leaves exactly the events of its own cycle
  a_clear_keeps_new: assert property ( // [RULE_12]
    esr_clear |=>
      esr_flags == $past(esr_set))
    else $error("clear lost an event or kept an old flag");

  // ****************************************************************
  // summary and reply assertions
  // ****************************************************************

  // each enabled level cause raises the summary
  a_mav_cause: assert property ( // [RULE_08]
    reply_pending_in && q.sre[status_pkg::STB_MAV] |-> mss)
    else $error("message available did not reach summary");

  a_err_cause: assert property ( // [RULE_09]
    error_queue_in && q.sre[status_pkg::STB_ERR] |-> mss)
    else $error("error queue did not reach summary");

  a_ready_cause: assert property ( // [RULE_22]
    ready_event_in && q.sre[status_pkg::STB_READY] |-> mss)
    else $error("ready events did not reach summary");

  // the service enable bit 6 alone can never raise the summary
  a_service_gate: assert property ( // [RULE_03]
    (q.sre & status_pkg::SRE_GATE_MASK) == 8'h00 |-> !mss)
    else $error("summary raised by service enable bit");

  // a reply appears only for a query and otherwise holds
  a_reply_needs_query: assert property ( // [RULE_20]
    !serial_poll_in && !status_query_in && !event_query_in |=>
      !reply_valid_out && $stable(reply_byte_out))
    else $error("reply changed without a query");

  // poll reply shares bits 5 to 0 with the status byte
  a_poll_reply_bits: assert property ( // [RULE_02]
    serial_poll_in |=>
      (reply_byte_out & 8'h3F) == ($past(stb_base) & 8'h3F))
    else $error("poll reply low bits wrong");

  // an event reply shows the flags as they stood before the read
  a_event_reply_raw: assert property ( // [RULE_20]
    event_query_in && !serial_poll_in && !status_query_in |=>
      reply_valid_out && reply_byte_out == $past(esr_flags))
    else $error("event reply is not the pre-read flags");

  c_poll_after_srq: cover property (srq_out ##[1:20] serial_poll_in);
  c_event_read: cover property (
    esr_flags[status_pkg::ESR_QYE] ##1 event_query_in);
  c_query_with_mss: cover property (mss && status_query_in);
  c_set_during_clear: cover property (esr_clear && op_complete_in);
  c_poll_drops_srq: cover property (srq_out && serial_poll_in && mss);
endmodule

// ===== tb.sv
// self-checking bench for the status summary and event reporting block
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end

module tb;
  // ****************************************************************
  // stimulus state and reference model
  // ****************************************************************
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] ev_q = 6'h00; // user, cmd, exe, dde, qye, opc
  logic rp = 1'b0, eq = 1'b0, rdy = 1'b0;
  logic sp, sq, eqy, cs, srw, esw, rv, srq;
  logic [7:0] wd, rb;
  logic [7:0] esr = 8'h80, sre = 8'h00, ese = 8'h00;
  logic rq = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'h5F7372E4;
  int errors = 0, num_checks = 0;

  // 125 MHz clock
  always #4 clk_in = ~clk_in;

  status_event_reporting u_status_event_reporting (
    .clk_in(clk_in), .rst_in(rst_in), .serial_poll_in(sp),
    .status_query_in(sq), .event_query_in(eqy), .clear_status_in(cs),
    .sre_write_in(srw), .ese_write_in(esw), .write_data_in(wd),
    .user_request_in(ev_q[5]), .command_error_in(ev_q[4]),
    .exec_error_in(ev_q[3]), .device_error_in(ev_q[2]),
    .query_error_in(ev_q[1]), .op_complete_in(ev_q[0]),
    .reply_pending_in(rp), .error_queue_in(eq), .ready_event_in(rdy),
    .reply_byte_out(rb), .reply_valid_out(rv), .srq_out(srq));

  host_model u_host_model (
    .clk_in(clk_in), .reply_valid_in(rv), .serial_poll_out(sp),
    .status_query_out(sq), .event_query_out(eqy), .clear_status_out(cs),
    .sre_write_out(srw), .ese_write_out(esw), .write_data_out(wd));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // status byte: bits 7, 3, 1 zero, bit 6 chosen by caller
  function automatic logic [7:0] stb(input logic b6);
    return {1'b0, b6, |(esr & ese), rp, 1'b0, eq, 1'b0, rdy};
  endfunction

  // summary of enabled causes, service bit masked off
  function automatic logic summ();
    return |(stb(1'b0) & sre & 8'hBF);
  endfunction

  task automatic conclude();
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // one operation: 0..5 host commands, 6 event pulses, 7 levels
  // ****************************************************************
  task automatic op(input int kind, input logic [7:0] d);
    bit ok;
    logic s0;
    s0 = summ();
    if (kind == 0) exp_q.push_back(stb(rq));
    if (kind == 1) exp_q.push_back(stb(summ()));
    if (kind == 2) exp_q.push_back(esr);
    if (kind == 6) begin
      @(posedge clk_in);
      ev_q <= d[5:0];
      @(posedge clk_in);
      ev_q <= 6'h00;
      esr = esr | {1'b0, d[5:1], 1'b0, d[0]}; // request control never set
    end else if (kind == 7) begin
      @(posedge clk_in);
      {rp, eq, rdy} <= d[2:0];
      @(posedge clk_in);
    end else begin
      u_host_model.send(kind, d, ok);
      if (!ok) begin
        errors++;
        conclude();
      end
      case (kind)
        0: rq = 1'b0;
        2, 3: esr = 8'h00;
        4: sre = d;
        5: ese = d;
        default: ;
      endcase
    end
    if (summ() && !s0) rq = 1'b1;
    if (!summ()) rq = 1'b0;
    @(posedge clk_in);
    #1;
    `CHK(srq, rq)
  endtask

  // ****************************************************************
  // reply monitor against the queue of expected bytes
  // ****************************************************************
  always @(posedge clk_in) begin
    logic [7:0] e;
    if (rv === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        e = exp_q.pop_front();
        `CHK(rb, e)
      end
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    bit ok;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    op(2, 8'h00); // power-on flag read then cleared
    op(2, 8'h00); // second read shows flags empty
    op(4, 8'h14); // message and error bits enabled
    op(7, 8'h04); // a reply waits, request raised
    op(0, 8'h00); // poll shows request flag
    op(0, 8'h00); // second poll sees it cleared
    op(1, 8'h00); // status query shows summary
    op(5, 8'hFF); // every event enabled
    op(6, 8'h3F); // all event sources at once
    op(1, 8'h00); // event summary set
    // an event in the read cycle: reply shows old flags, event survives
    exp_q.push_back(esr);
    fork
      u_host_model.send(2, 8'h00, ok);
      begin
        @(posedge clk_in);
        ev_q <= 6'h01;
        @(posedge clk_in);
        ev_q <= 6'h00;
      end
    join
    if (!ok) begin
      errors++;
      conclude();
    end
    esr = 8'h01;
    op(2, 8'h00); // only the surviving completion flag remains
    op(3, 8'h00); // clear status while the flags are already empty after the read
    for (int i = 0; i < 600; i++) begin
      lfsr = next_rand(lfsr);
      op(lfsr[2:0], lfsr[15:8]);
    end
    `CHK(exp_q.size() == 0, 1'b1)
    conclude();
  end
endmodule
